/* File: bench/array_ctrl_props.sv */
// assertion checker for the logic array control block
`timescale 1ns/100ps
`default_nettype none
module array_ctrl_props
    import array_ctrl_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [ELEM_N-1:0] element_out,
    input wire logic [ELEM_N-1:0] element_sw_in,
    input wire logic              array_interrupt_first,
    input wire logic              array_interrupt_second,
    input wire logic              conv_start,
    input wire logic              irq
);
    logic [15:0] wd_lo;
    assign wd_lo = wdata[15:0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // element word held still so the one-cycle sampling delay cannot matter
    sequence rd_out;
        rd && addr == OFF_OUTPUT_WORD && $stable(element_out);
    endsequence
    sequence wr_in;
        wr && addr == OFF_INPUT_WORD;
    endsequence
    AST_OUT_WORD: assert property (
        rd_out |=> rdata == {16'h0000, $past(element_out, 2)})
        else $error("output word read mismatch");
    AST_RD_IDLE: assert property (
        !$past(rd) |-> rdata == 32'h00000000)
        else $error("read data outside read answer");
    AST_IN_WORD: assert property (
        wr_in |=> element_sw_in == $past(wd_lo))
        else $error("input word not applied");
    AST_FIRST_LVL: assert property (
        array_interrupt_first |-> element_out != 16'h0000)
        else $error("first interrupt without element");
    AST_SECOND_LVL: assert property (
        array_interrupt_second |-> element_out != 16'h0000)
        else $error("second interrupt without element");
    AST_CONV_LVL: assert property (
        conv_start |-> element_out != 16'h0000)
        else $error("conversion start without element");
    AST_FIRST_FALL: assert property (
        $fell(array_interrupt_first) && !$past(wr)
        |-> element_out != $past(element_out))
        else $error("first interrupt dropped on its own");
    AST_IRQ_HOLD: assert property (
        irq && !wr |=> irq)
        else $error("event interrupt cleared without write");
endmodule : array_ctrl_props
`default_nettype wire

/* File: bench/programmable_logic_array_ctrl_test.sv */
// testbench for the logic array control block
`timescale 1ns/100ps
`default_nettype none
module programmable_logic_array_ctrl_test;
    import array_ctrl_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        pin5 = 1'b0, tie0 = 1'b0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
    logic [15:0] elem = 16'h0, sw_in, fb_e, fb_o;
    logic        en0, en1, irq_a, irq_b, conv, irq;
    int          err_total = 0, n_checks = 0, cyc = 0;
    programmable_logic_array_ctrl uut (
        .clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata,
        .port0_pin5(pin5), .port0_pin0(tie0), .port0_pin7(tie0),
        .crystal_32k_clock(tie0), .timer1_overflow(tie0),
        .element_out(elem), .element_sw_in(sw_in), .fb_even(fb_e),
        .fb_odd(fb_o), .block0_clk_en(en0), .block1_clk_en(en1),
        .array_interrupt_first(irq_a), .array_interrupt_second(irq_b),
        .conv_start(conv), .irq);
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wreg(logic [31:0] a, logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask : wreg
    task automatic rreg(logic [31:0] a, logic [31:0] exp, string nm);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk(nm, rdata, exp);
    endtask : rreg
    task automatic eo(logic [15:0] v);
        @(posedge clk_sys);
        elem <= v;
        #1;
    endtask : eo
    task automatic t_reset;
        rreg(OFF_CLOCK_SELECT, 32'h0, "clk_sel");
        rreg(OFF_IRQ_ROUTE, 32'h0, "route");
        rreg(OFF_CONV_TRIGGER, 32'h0, "conv_trig");
        rreg(OFF_INPUT_WORD, 32'h0, "in_word");
        rreg(OFF_OUTPUT_WORD, 32'h0, "out_word");
        rreg(OFF_CONFIG_LOCK, 32'h0, "lock");
        rreg(32'hFFFF0BF0, 32'h0, "unmapped");
        $display("reset test done");
    endtask : t_reset
    task automatic t_route;
        for (int s = 0; s < 16; s++)
        begin
            wreg(OFF_IRQ_ROUTE, 32'h1010 | s << 8 | (15 - s));
            eo(16'h1 << s);
            chk("irq_second", irq_b, 1'b1);
            chk("irq_first", irq_a, 1'b0);
            eo(16'h1 << (15 - s));
            chk("irq_first", irq_a, 1'b1);
            chk("irq_second", irq_b, 1'b0);
            wreg(OFF_CONV_TRIGGER, 32'h10 | s);
            eo(~(16'h1 << s));
            chk("conv", conv, 1'b0);
            eo(16'h1 << s);
            chk("conv", conv, 1'b1);
        end
        rreg(OFF_IRQ_ROUTE, 32'h1F10, "route");
        wreg(OFF_IRQ_ROUTE, 32'hEFEF);
        wreg(OFF_CONV_TRIGGER, 32'hF);
        eo(16'hFFFF);
        chk("disabled", {irq_a, irq_b, conv}, 32'h0);
        $display("route test done");
    endtask : t_route
    task automatic t_words;
        wreg(OFF_INPUT_WORD, 32'h1234A5C3);
        chk("sw_in", sw_in, 16'hA5C3);
        rreg(OFF_INPUT_WORD, 32'h0000A5C3, "in_word");
        eo(16'h5AC3);
        rreg(OFF_OUTPUT_WORD, 32'h00005AC3, "out_word");
        eo(16'hC35A);
        rreg(OFF_OUTPUT_WORD, 32'h0000C35A, "out_word");
        $display("word test done");
    endtask : t_words
    task automatic t_fb;
        int el[4] = '{0, 3, 8, 12};
        int e, ev, od;
        for (int i = 0; i < 4; i++)
            for (int c = 0; c < 4; c++)
            begin
                e = el[i];
                ev = c ? (e & 8) + 2 * c : (e == 0 ? 15 : (e == 8 ? 7 : e & 8));
                od = (e & 8) + 1 + 2 * (3 - c);
                wreg(OFF_ELEM_BASE + 4 * e, c << 9 | (3 - c) << 7);
                eo(16'h1 << ev);
                chk("fb_even", fb_e[e], 1'b1);
                eo(16'h1 << od);
                chk("fb_odd", fb_o[e], 1'b1);
                chk("fb_even", fb_e[e], 1'b0);
            end
        $display("feedback test done");
    endtask : t_fb
    task automatic t_clk;
        int n = 0;
        wreg(OFF_CLOCK_SELECT, 32'h33);
        chk("clk_en", {en1, en0}, 2'b11);
        wreg(OFF_CLOCK_SELECT, 32'h76);
        chk("clk_en", {en1, en0}, 2'b00);
        wreg(OFF_CLOCK_SELECT, 32'h00);
        // pin clock kept far below its ceiling, one slow edge only
        @(posedge clk_sys);
        pin5 <= 1'b1;
        // pin edge is resynchronised, so allow a few cycles of latency
        repeat (8)
        begin
            @(posedge clk_sys);
            #1 n += en0 + en1;
        end
        chk("pin_pulses", n, 2);
        @(posedge clk_sys);
        pin5 <= 1'b0;
        $display("clock test done");
    endtask : t_clk
    task automatic t_irq;
        eo(16'h0);
        wreg(OFF_IRQ_ROUTE, 32'h10);
        wreg(OFF_EVENT_STATUS, 32'h7);
        wreg(OFF_EVENT_MASK, 32'h1);
        chk("irq", irq, 1'b0);
        eo(16'h1);
        repeat (3) @(posedge clk_sys);
        #1 chk("irq", irq, 1'b1);
        eo(16'h0);
        chk("irq", irq, 1'b1);
        rreg(OFF_EVENT_STATUS, 32'h1, "status");
        wreg(OFF_EVENT_MASK, 32'h0);
        chk("irq", irq, 1'b0);
        wreg(OFF_EVENT_MASK, 32'h1);
        chk("irq", irq, 1'b1);
        wreg(OFF_EVENT_STATUS, 32'h1);
        chk("irq", irq, 1'b0);
        $display("event test done");
    endtask : t_irq
    task automatic t_lock;
        wreg(OFF_CONFIG_LOCK, 32'h1);
        wreg(OFF_CONFIG_LOCK, 32'h0);
        rreg(OFF_CONFIG_LOCK, 32'h0, "lock");
        wreg(OFF_IRQ_ROUTE, 32'h1FFF);
        rreg(OFF_IRQ_ROUTE, 32'h10, "route");
        wreg(OFF_CLOCK_SELECT, 32'h33);
        rreg(OFF_CLOCK_SELECT, 32'h0, "clk_sel");
        wreg(OFF_INPUT_WORD, 32'h0000BEEF);
        rreg(OFF_INPUT_WORD, 32'h0000BEEF, "in_word");
        $display("lock test done");
    endtask : t_lock
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            test_done;
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        t_route;
        t_words;
        t_fb;
        t_clk;
        t_irq;
        t_lock;
        test_done;
    end
endmodule : programmable_logic_array_ctrl_test
bind programmable_logic_array_ctrl array_ctrl_props u_props (
    .clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata, .element_out,
    .element_sw_in, .array_interrupt_first, .array_interrupt_second,
    .conv_start, .irq);
`default_nettype wire

/* File: pkg/array_ctrl_pkg.sv */
// constants for the logic array control block
package array_ctrl_pkg;
    localparam int          ADDR_W      = 32;
    localparam int          DATA_W      = 32;
    localparam int          ELEM_N      = 16;
    localparam int          SEL_W       = 4;
    localparam int          CLK_SEL_W   = 3;
    localparam int          FB_W        = 2;

    localparam logic [31:0] OFF_CLOCK_SELECT = 32'hFFFF0B40;
    localparam logic [31:0] OFF_IRQ_ROUTE    = 32'hFFFF0B44;
    localparam logic [31:0] OFF_CONV_TRIGGER = 32'hFFFF0B48;
    localparam logic [31:0] OFF_INPUT_WORD   = 32'hFFFF0B4C;
    localparam logic [31:0] OFF_OUTPUT_WORD  = 32'hFFFF0B50;
    localparam logic [31:0] OFF_CONFIG_LOCK  = 32'hFFFF0B54;
    localparam logic [31:0] OFF_EVENT_STATUS = 32'hFFFF0B58;
    localparam logic [31:0] OFF_EVENT_MASK   = 32'hFFFF0B5C;
    localparam logic [31:0] OFF_ELEM_BASE    = 32'hFFFF0B60;

    localparam int B1_CLK_LSB   = 4;
    localparam int B0_CLK_LSB   = 0;
    localparam int ARRAY_INTERRUPT_SECOND_SRC_LSB = 8;
    localparam int ARRAY_INTERRUPT_SECOND_EN_BIT  = 12;
    localparam int ARRAY_INTERRUPT_FIRST_SRC_LSB = 0;
    localparam int ARRAY_INTERRUPT_FIRST_EN_BIT  = 4;
    localparam int CONV_EN_BIT  = 4;
    localparam int CONV_SRC_LSB = 0;
    localparam int LOCK_BIT     = 0;
    localparam int FB_EVEN_LSB  = 9;
    localparam int FB_ODD_LSB   = 7;
    localparam int ELEM_CFG_W   = 11;
    localparam int EV_W         = 3;

    localparam logic [7:0]  CLOCK_SELECT_RST = 8'h00;
    localparam logic [12:0] IRQ_ROUTE_RST    = 13'h0000;
    localparam logic [4:0]  CONV_TRIGGER_RST = 5'h00;
    localparam logic [15:0] INPUT_WORD_RST   = 16'h0000;
    localparam logic [10:0] ELEM_CFG_RST     = 11'h000;
    localparam logic [2:0]  EV_RST           = 3'h0;

    localparam logic [2:0] CLK_PIN5    = 3'h0;
    localparam logic [2:0] CLK_PIN0    = 3'h1;
    localparam logic [2:0] CLK_PIN7    = 3'h2;
    localparam logic [2:0] CLK_CORE    = 3'h3;
    localparam logic [2:0] CLK_CRYSTAL = 3'h4;
    localparam logic [2:0] CLK_TIMER1  = 3'h5;

    localparam int GPIO_CLK_MAX_MHZ = 44;

    localparam int EV_ARRAY_INTERRUPT_FIRST = 0;
    localparam int EV_ARRAY_INTERRUPT_SECOND = 1;
    localparam int EV_CONV = 2;
endpackage : array_ctrl_pkg

/* File: src/programmable_logic_array_ctrl.sv */
// control and register logic around the sixteen-element logic array
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - block 1 clock from bits 6:4
// - block 0 clock from bits 2:0
// - bit 12 enables second interrupt from 11:8
// - bit 4 enables first interrupt from 3:0
// - conversion trigger element gated by bit 4
// - input word bit n feeds element n
// - output word shows element outputs
// - output word refreshed every cycle
// - lock bit accepts one write only
// - lock freezes all but input word, event status and event mask
// - even feedback select bits 10:9
// - odd feedback select bits 8:7
module programmable_logic_array_ctrl
    import array_ctrl_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [ADDR_W-1:0]     addr,
    input  wire logic [DATA_W-1:0]     wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [DATA_W-1:0]     rdata,
    input  wire logic                  port0_pin5,
    input  wire logic                  port0_pin0,
    input  wire logic                  port0_pin7,
    input  wire logic                  crystal_32k_clock,
    input  wire logic                  timer1_overflow,
    input  wire logic [ELEM_N-1:0]     element_out,
    output logic      [ELEM_N-1:0]     element_sw_in,
    output logic      [ELEM_N-1:0]     fb_even,
    output logic      [ELEM_N-1:0]     fb_odd,
    output logic                       block0_clk_en,
    output logic                       block1_clk_en,
    output logic                       array_interrupt_first,
    output logic                       array_interrupt_second,
    output logic                       conv_start,
    output logic                       irq
);

    // the array runs in this clock domain, so element outputs need no sync
    logic [7:0]            clock_select_q;
    logic [12:0]           irq_route_q;
    logic [4:0]            conv_trigger_q;
    logic [15:0]           input_word_q;
    logic                  lock_q;
    logic                  lock_written_q;
    logic [ELEM_CFG_W-1:0] elem_cfg_q [ELEM_N];
    logic [ELEM_N-1:0]     out_word_q;
    logic [EV_W-1:0]       ev_status_q;
    logic [EV_W-1:0]       ev_mask_q;
    logic [EV_W-1:0]       ev_level_q;
    logic [EV_W-1:0]       ev_now;
    logic [2:0]            ext_s1_q;
    logic [2:0]            ext_s2_q;
    logic [2:0]            ext_s3_q;
    logic [1:0]            slow_s1_q;
    logic [1:0]            slow_s2_q;
    logic [1:0]            slow_s3_q;
    logic [DATA_W-1:0]     rdata_q;
    logic                  cfg_ok;

    function automatic logic elem_pick(input logic [ELEM_N-1:0] v,
                                       input logic [SEL_W-1:0]  s);
        elem_pick = v[s];
    endfunction : elem_pick

    // rising edge of a selected clock source, one core cycle wide
    function automatic logic clk_pick(input logic [2:0] sel,
                                      input logic [2:0] rise,
                                      input logic [1:0] srise);
        unique case (sel)
            CLK_PIN5:    clk_pick = rise[0];
            CLK_PIN0:    clk_pick = rise[1];
            CLK_PIN7:    clk_pick = rise[2];
            CLK_CORE:    clk_pick = 1'b1;
            CLK_CRYSTAL: clk_pick = srise[0];
            CLK_TIMER1:  clk_pick = srise[1];
            default:     clk_pick = 1'b0;
        endcase
    endfunction : clk_pick

    assign cfg_ok = wr && !lock_q;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ext_s1_q  <= 3'h0;
            ext_s2_q  <= 3'h0;
            ext_s3_q  <= 3'h0;
            slow_s1_q <= 2'h0;
            slow_s2_q <= 2'h0;
            slow_s3_q <= 2'h0;
        end
        else
        begin
            ext_s1_q  <= {port0_pin7, port0_pin0, port0_pin5};
            ext_s2_q  <= ext_s1_q;
            ext_s3_q  <= ext_s2_q;
            slow_s1_q <= {timer1_overflow, crystal_32k_clock};
            slow_s2_q <= slow_s1_q;
            slow_s3_q <= slow_s2_q;
        end
    end

    // pin clocks are resampled, so only rates well below clk_sys/2 pass
    always_comb
    begin
        block1_clk_en = clk_pick(clock_select_q[B1_CLK_LSB +: CLK_SEL_W],
                                 ext_s2_q & ~ext_s3_q,
                                 slow_s2_q & ~slow_s3_q);
        block0_clk_en = clk_pick(clock_select_q[B0_CLK_LSB +: CLK_SEL_W],
                                 ext_s2_q & ~ext_s3_q,
                                 slow_s2_q & ~slow_s3_q);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            clock_select_q <= CLOCK_SELECT_RST;
        else if (cfg_ok && addr == OFF_CLOCK_SELECT)
            clock_select_q <= wdata[7:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            irq_route_q <= IRQ_ROUTE_RST;
        else if (cfg_ok && addr == OFF_IRQ_ROUTE)
            irq_route_q <= wdata[12:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            conv_trigger_q <= CONV_TRIGGER_RST;
        else if (cfg_ok && addr == OFF_CONV_TRIGGER)
            conv_trigger_q <= wdata[4:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            input_word_q <= INPUT_WORD_RST;
        else if (wr && addr == OFF_INPUT_WORD)
            input_word_q <= wdata[15:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lock_q         <= 1'b0;
            lock_written_q <= 1'b0;
        end
        else if (wr && addr == OFF_CONFIG_LOCK && !lock_written_q)
        begin
            lock_q         <= wdata[LOCK_BIT];
            lock_written_q <= 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < ELEM_N; g++)
        begin : g_elem
            localparam logic [31:0] ELEM_OFF =
                OFF_ELEM_BASE + 32'(4 * g);
            localparam int EV_BASE  = (g < 8) ? 0 : 8;
            localparam int EV_ZERO  =
                (g == 0) ? 15 : (g < 8) ? 0 : (g == 8) ? 7 : 8;
            logic [FB_W-1:0] se;
            logic [FB_W-1:0] so;

            always_ff @(posedge clk_sys)
            begin
                if (rst)
                    elem_cfg_q[g] <= ELEM_CFG_RST;
                else if (cfg_ok && addr == ELEM_OFF)
                    elem_cfg_q[g] <= wdata[ELEM_CFG_W-1:0];
            end

            assign se = elem_cfg_q[g][FB_EVEN_LSB +: FB_W];
            assign so = elem_cfg_q[g][FB_ODD_LSB +: FB_W];
            assign fb_even[g] = (se == 2'h0) ? element_out[EV_ZERO]
                              : element_out[EV_BASE + 2 * int'(se)];
            assign fb_odd[g] = element_out[EV_BASE + 1 + 2 * int'(so)];
        end
    endgenerate

    assign element_sw_in = input_word_q;

    assign array_interrupt_first = irq_route_q[ARRAY_INTERRUPT_FIRST_EN_BIT] &&
        elem_pick(element_out, irq_route_q[ARRAY_INTERRUPT_FIRST_SRC_LSB +: SEL_W]);
    assign array_interrupt_second = irq_route_q[ARRAY_INTERRUPT_SECOND_EN_BIT] &&
        elem_pick(element_out, irq_route_q[ARRAY_INTERRUPT_SECOND_SRC_LSB +: SEL_W]);
    assign conv_start = conv_trigger_q[CONV_EN_BIT] &&
        elem_pick(element_out, conv_trigger_q[CONV_SRC_LSB +: SEL_W]);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            out_word_q <= '0;
        else
            out_word_q <= element_out;
    end

    assign ev_now = {conv_start, array_interrupt_second,
                     array_interrupt_first};

    // status catches rising edges; a new edge beats a clear
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ev_level_q  <= EV_RST;
            ev_status_q <= EV_RST;
        end
        else
        begin
            ev_level_q <= ev_now;
            if (wr && addr == OFF_EVENT_STATUS)
                ev_status_q <= (ev_status_q & ~wdata[EV_W-1:0])
                             | (ev_now & ~ev_level_q);
            else
                ev_status_q <= ev_status_q | (ev_now & ~ev_level_q);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ev_mask_q <= EV_RST;
        else if (wr && addr == OFF_EVENT_MASK)
            ev_mask_q <= wdata[EV_W-1:0];
    end

    assign irq = |(ev_status_q & ev_mask_q);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rdata_q <= '0;
        else if (rd)
        begin
            rdata_q <= '0;
            if (addr == OFF_CLOCK_SELECT)
                rdata_q <= {24'h000000, clock_select_q};
            else if (addr == OFF_IRQ_ROUTE)
                rdata_q <= {19'h00000, irq_route_q};
            else if (addr == OFF_CONV_TRIGGER)
                rdata_q <= {27'h0000000, conv_trigger_q};
            else if (addr == OFF_INPUT_WORD)
                rdata_q <= {16'h0000, input_word_q};
            else if (addr == OFF_OUTPUT_WORD)
                rdata_q <= {16'h0000, out_word_q};
            else if (addr == OFF_EVENT_STATUS)
                rdata_q <= {29'h00000000, ev_status_q};
            else if (addr == OFF_EVENT_MASK)
                rdata_q <= {29'h00000000, ev_mask_q};
            else
                for (int i = 0; i < ELEM_N; i++)
                    if (addr == OFF_ELEM_BASE + 32'(4 * i))
                        rdata_q <= {21'h000000, elem_cfg_q[i]};
        end
        else
            rdata_q <= '0;
    end

    assign rdata = rdata_q;

endmodule : programmable_logic_array_ctrl

`default_nettype wire
